// [ecwd_top.sv]
/*
  embedded controller watchdog: apb register file, start delay, timeout
  countdown and one timeout action (reset, short or long power-button press).
  assumes one clock, a synchronous reset and an apb master on the same clock.
*/
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ns
// What this block does
// [RULE1] disabled watchdog never counts nor acts
// [RULE2] expiry performs exactly one configured action
// [RULE3] reset action asserts module reset request
// [RULE4] short press holds power button one second
// [RULE5] long press holds power button four seconds
// [RULE6] programmable start delay 0 to 600 s
// [RULE7] timeout 20 to 600 s, set while enabled
// [RULE8] host refresh reloads the full timeout
module ecwd_top #(
  parameter int SEC_CYCLES = ecwd_pkg::SEC_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic sysResetReq,
  output logic pwrBtnReq
);

  ecwd_pkg::ecwd_cfg_t cfg_reg; // software settings
  ecwd_pkg::ecwd_cfg_t cfg_next;
  ecwd_pkg::ecwd_state_t state_reg; // sequence position
  ecwd_pkg::ecwd_state_t state_next;
  logic [9:0] secCnt_reg; // seconds left in the current phase
  logic [9:0] secCnt_next;
  logic [31:0] prdata_reg; // read data latched in the first enabled bus cycle
  logic rdReady_reg; // read data loaded, the access phase may end
  logic sysResetReq_reg;
  logic pwrBtnReq_reg;
  logic tickRestart;
  logic tick;

  // apb decode
  wire accessEnd = psel && penable && rdReady_reg; // access phase that completes
  wire accessWr = accessEnd && pwrite && ce;
  wire hitCtrl = (paddr == ecwd_pkg::OFF_CTRL);
  wire hitDelay = (paddr == ecwd_pkg::OFF_DELAY);
  wire hitTimeout = (paddr == ecwd_pkg::OFF_TIMEOUT);
  wire hitRefresh = (paddr == ecwd_pkg::OFF_REFRESH);
  wire hitStatus = (paddr == ecwd_pkg::OFF_STATUS);
  wire mapped = hitCtrl || hitDelay || hitTimeout || hitRefresh || hitStatus;
  wire wrCtrl = accessWr && hitCtrl;
  wire wrDelay = accessWr && hitDelay;
  wire wrTimeout = accessWr && hitTimeout;
  wire wrRefresh = accessWr && hitRefresh;

  // fields of a control write
  wire wrEnable = pwdata[ecwd_pkg::CTRL_EN_BIT];
  wire [1:0] wrAct = pwdata[ecwd_pkg::CTRL_ACT_LSB +: 2];
  wire actLegal = (wrAct != 2'b11);

  // sequence requests
  wire startReq = wrCtrl && wrEnable && (state_reg == ecwd_pkg::ST_IDLE);
  wire stopReq = wrCtrl && !wrEnable;
  wire refreshReq = wrRefresh && cfg_reg.enable;
  wire actDone = (state_reg == ecwd_pkg::ST_ACT) && tick && (secCnt_reg <= 10'h001);

  // hold time of the selected action
  wire [9:0] holdSec = (cfg_reg.action == ecwd_pkg::ACT_LONG) ? ecwd_pkg::HOLD_LONG_S :
                       (cfg_reg.action == ecwd_pkg::ACT_SHORT) ? ecwd_pkg::HOLD_SHORT_S :
                       ecwd_pkg::HOLD_RESET_S;

  // read words
  wire [31:0] ctrlWord = {29'h0, cfg_reg.action, cfg_reg.enable};
  wire [31:0] delayWord = {22'h0, cfg_reg.delay};
  wire [31:0] timeoutWord = {22'h0, cfg_reg.timeout};
  wire [31:0] statusWord = {6'h0, secCnt_reg, 13'h0, state_reg};
  wire [31:0] readMux = hitCtrl ? ctrlWord :
                        hitDelay ? delayWord :
                        hitTimeout ? timeoutWord :
                        hitStatus ? statusWord : 32'h0000_0000;

  // handshake: no wait state unless ce froze the setup or the access cycle
  assign pready = ce && rdReady_reg;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_reg;
  assign sysResetReq = sysResetReq_reg;
  assign pwrBtnReq = pwrBtnReq_reg;

  // second time base, restarted on entry to the delay, count and action phases and on refresh
  ecwd_sec_tick #(
    .CYCLES(SEC_CYCLES)
  ) u_tick (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .restart(tickRestart),
    .tick(tick)
  );

  // configuration updates
  always_comb
  begin
    cfg_next = cfg_reg;
    // hardware disables after the action has run its course
    if (actDone)
      cfg_next.enable = 1'b0;
    if (wrCtrl)
    begin
      cfg_next.enable = wrEnable; // [RULE1]
      // action is chosen only while enabling or enabled, never mid-action
      if (wrEnable && actLegal && (state_reg != ecwd_pkg::ST_ACT))
        cfg_next.action = ecwd_pkg::ecwd_action_t'(wrAct); // [RULE2]
    end
    // delay and timeout are locked while disabled
    if (wrDelay && cfg_reg.enable)
      cfg_next.delay = ecwd_pkg::clampSec(pwdata, ecwd_pkg::DELAY_MIN,
                                          ecwd_pkg::DELAY_MAX); // [RULE6]
    if (wrTimeout && cfg_reg.enable)
      cfg_next.timeout = ecwd_pkg::clampSec(pwdata, ecwd_pkg::TIMEOUT_MIN,
                                            ecwd_pkg::TIMEOUT_MAX); // [RULE7]
  end

  // watchdog sequence
  always_comb
  begin
    state_next = state_reg;
    secCnt_next = secCnt_reg;
    tickRestart = 1'b0;
    case (state_reg)
      ecwd_pkg::ST_IDLE:
      begin
        // enabling loads the start delay
        if (startReq)
        begin
          state_next = ecwd_pkg::ST_DELAY;
          secCnt_next = cfg_reg.delay; // [RULE6]
          tickRestart = 1'b1;
        end
      end
      ecwd_pkg::ST_DELAY:
      begin
        // delay over: begin counting the timeout
        if (secCnt_reg == 10'h000)
        begin
          state_next = ecwd_pkg::ST_COUNT;
          secCnt_next = cfg_reg.timeout; // [RULE6]
          tickRestart = 1'b1;
        end
        else if (tick)
          secCnt_next = secCnt_reg - 10'h001;
      end
      ecwd_pkg::ST_COUNT:
      begin
        // refresh reloads the full timeout and a fresh second
        if (refreshReq)
        begin
          secCnt_next = cfg_reg.timeout; // [RULE8]
          tickRestart = 1'b1;
        end
        else if (tick)
        begin
          // last second gone: fire the one selected action
          if (secCnt_reg <= 10'h001)
          begin
            state_next = ecwd_pkg::ST_ACT; // [RULE2]
            secCnt_next = holdSec; // [RULE4] [RULE5]
            tickRestart = 1'b1;
          end
          else
            secCnt_next = secCnt_reg - 10'h001;
        end
      end
      ecwd_pkg::ST_ACT:
      begin
        // hold the action for its length in whole seconds
        if (tick)
        begin
          if (secCnt_reg <= 10'h001)
          begin
            state_next = ecwd_pkg::ST_IDLE;
            secCnt_next = 10'h000;
          end
          else
            secCnt_next = secCnt_reg - 10'h001;
        end
      end
      default:
      begin
        state_next = ecwd_pkg::ST_IDLE;
        secCnt_next = 10'h000;
      end
    endcase
    // disabling stops everything, action included
    if (stopReq)
    begin
      state_next = ecwd_pkg::ST_IDLE; // [RULE1]
      secCnt_next = 10'h000;
    end
  end

  // action outputs decoded from the next state
  wire inActNext = (state_next == ecwd_pkg::ST_ACT);
  wire resetNext = inActNext && (cfg_next.action == ecwd_pkg::ACT_RESET); // [RULE3]
  wire pressNext = inActNext && (cfg_next.action != ecwd_pkg::ACT_RESET); // [RULE4] [RULE5]

  // state registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cfg_reg <= '{1'b0, ecwd_pkg::ACT_RESET, ecwd_pkg::DELAY_RST, ecwd_pkg::TIMEOUT_RST};
      state_reg <= ecwd_pkg::ST_IDLE;
      secCnt_reg <= 10'h000;
      sysResetReq_reg <= 1'b0;
      pwrBtnReq_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      rdReady_reg <= 1'b0;
    end
    else if (ce)
    begin
      cfg_reg <= cfg_next;
      state_reg <= state_next;
      secCnt_reg <= secCnt_next;
      sysResetReq_reg <= resetNext;
      pwrBtnReq_reg <= pressNext;
      // completion consumes the loaded word
      if (accessEnd)
        rdReady_reg <= 1'b0;
      // load once per transfer, late if ce was low in the setup cycle
      else if (psel)
      begin
        rdReady_reg <= 1'b1;
        prdata_reg <= readMux;
      end
    end
  end

  // helper: cycles for which the power-button request has been held
  int holdCyc;
  always_ff @(posedge clock)
  begin
    if (rst)
      holdCyc <= 0;
    else if (ce)
      holdCyc <= pwrBtnReq_reg ? holdCyc + 1 : 0;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  disabled_quiet_a: assert property (!cfg_reg.enable |-> state_reg == ecwd_pkg::ST_IDLE && !sysResetReq && !pwrBtnReq) else $error("disabled watchdog active"); // [RULE1]
  single_action_a: assert property (!(sysResetReq && pwrBtnReq)) else $error("two actions at once"); // [RULE2]
  reset_kind_a: assert property (sysResetReq |-> cfg_reg.action == ecwd_pkg::ACT_RESET && state_reg == ecwd_pkg::ST_ACT) else $error("reset without reset action"); // [RULE3]
  short_len_a: assert property (pwrBtnReq && cfg_reg.action == ecwd_pkg::ACT_SHORT |-> holdCyc < SEC_CYCLES * 1) else $error("short press too long"); // [RULE4]
  long_len_a: assert property (pwrBtnReq && cfg_reg.action == ecwd_pkg::ACT_LONG |-> holdCyc < SEC_CYCLES * 4) else $error("long press too long"); // [RULE5]
  delay_end_a: assert property (ce && state_reg == ecwd_pkg::ST_DELAY && secCnt_reg == 10'h000 && !stopReq |=> state_reg == ecwd_pkg::ST_COUNT && secCnt_reg == $past(cfg_reg.timeout)) else $error("delay did not start count"); // [RULE6]
  timeout_lock_a: assert property (!cfg_reg.enable |=> $stable(cfg_reg.timeout) && $stable(cfg_reg.delay)) else $error("setting changed while disabled"); // [RULE7]
  refresh_load_a: assert property (ce && refreshReq && state_reg == ecwd_pkg::ST_COUNT && !stopReq |=> secCnt_reg == $past(cfg_reg.timeout)) else $error("refresh did not reload"); // [RULE8]

  reset_fire_c: cover property (ce && $rose(sysResetReq));
  short_fire_c: cover property ($rose(pwrBtnReq) && cfg_reg.action == ecwd_pkg::ACT_SHORT);
  long_fire_c: cover property ($rose(pwrBtnReq) && cfg_reg.action == ecwd_pkg::ACT_LONG);
  refresh_c: cover property (refreshReq && state_reg == ecwd_pkg::ST_COUNT);

endmodule

// [ecwd_pkg.sv]
/*
  shared constants, types and helpers for the embedded controller watchdog.
  assumes a 10 MHz controller clock and an APB master with 32-bit data.
*/
package ecwd_pkg;

  // apb register byte offsets
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DELAY = 8'h04;
  localparam logic [7:0] OFF_TIMEOUT = 8'h08;
  localparam logic [7:0] OFF_REFRESH = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;

  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ACT_LSB = 1;
  localparam int STAT_CNT_LSB = 16;
  localparam int SEC_W = 10;

  // second counts and their limits
  localparam logic [9:0] DELAY_MIN = 10'h000;
  localparam logic [9:0] DELAY_MAX = 10'h258;
  localparam logic [9:0] TIMEOUT_MIN = 10'h014;
  localparam logic [9:0] TIMEOUT_MAX = 10'h258;

  // values after reset
  localparam logic [9:0] DELAY_RST = 10'h000;
  localparam logic [9:0] TIMEOUT_RST = 10'h003C;

  // how long each action is held, in seconds
  localparam logic [9:0] HOLD_RESET_S = 10'h001;
  localparam logic [9:0] HOLD_SHORT_S = 10'h001;
  localparam logic [9:0] HOLD_LONG_S = 10'h004;

  // time base: one second expressed in clock cycles
  localparam int SECOND_NS = 1_000_000_000;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;

  // timeout actions
  typedef enum logic [1:0] {
    ACT_RESET = 2'b00,
    ACT_SHORT = 2'b01,
    ACT_LONG = 2'b10
  } ecwd_action_t;

  // watchdog sequence
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DELAY = 3'b001,
    ST_COUNT = 3'b010,
    ST_ACT = 3'b011
  } ecwd_state_t;

  // software configuration carried as one word
  typedef struct packed {
    logic enable;
    ecwd_action_t action;
    logic [9:0] delay;
    logic [9:0] timeout;
  } ecwd_cfg_t;

  // clamps a written word into a second range
  function automatic logic [9:0] clampSec(input logic [31:0] v, input logic [9:0] lo,
                                          input logic [9:0] hi);
    logic [9:0] r;
    r = v[9:0];
    if (v < {22'h0, lo})
      r = lo;
    else if (v > {22'h0, hi})
      r = hi;
    return r;
  endfunction

endpackage

// [ecwd_sec_tick.sv]
/*
  one-second tick generator for the watchdog.
  assumes restart comes from logic on the same clock; ce freezes the count.
*/
`timescale 1ns/1ns
module ecwd_sec_tick #(
  parameter int CYCLES = 10000000
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic restart,
  output logic tick
);

  localparam int W = (CYCLES > 2) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_reg; // cycles into the current second
  logic [W-1:0] cnt_next;
  wire atLast = (cnt_reg == LAST);

  // tick ignores restart: the consumer ranks restart above the tick, and
  // reading restart here would close a loop through the sequence logic
  assign tick = ce && atLast;
  assign cnt_next = (restart || atLast) ? '0 : W'(cnt_reg + 1'b1);

  // prescaler, cleared by restart and after its last cycle
  always_ff @(posedge clock)
  begin
    if (rst)
      cnt_reg <= '0;
    else if (ce)
      cnt_reg <= cnt_next;
  end

endmodule

// [ecwd_host_model.sv]
/*
  host platform model: watches the reset and power-button requests and
  reports each finished request with which lines were seen and its length.
  assumes the watchdog clock and reset; requests are level signals.
*/
`timescale 1ns/1ns
module ecwd_host_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic sysResetReq,
  input wire logic pwrBtnReq,
  output logic done,
  output logic [1:0] kind,
  output logic [31:0] len
);
  logic [1:0] seenReg; // lines seen during this request
  logic [31:0] cntReg; // cycles the request has stood

  // measure each request; both lines at once shows up as kind 3
  always_ff @(posedge clock)
  begin
    done <= 1'b0;
    if (rst)
    begin
      seenReg <= 2'b00;
      cntReg <= 32'h0000_0000;
    end
    else if (sysResetReq || pwrBtnReq)
    begin
      seenReg <= seenReg | {sysResetReq, pwrBtnReq};
      cntReg <= cntReg + 32'h0000_0001;
    end
    else if (cntReg != 32'h0000_0000)
    begin
      // request released: hand the measurement over for one cycle
      done <= 1'b1;
      kind <= seenReg;
      len <= cntReg;
      seenReg <= 2'b00;
      cntReg <= 32'h0000_0000;
    end
  end
endmodule

// [tb_top.sv]
/*
  watchdog bench: apb master, expectation queues, output monitor.
  assumes ecwd_pkg, ecwd_top and ecwd_host_model are compiled first.
*/
`timescale 1ns/1ns
module tb_top;
  localparam int SC = 8; // shortened second, in cycles
  logic clock = 1'b0; // controller clock
  logic rst = 1'b1; // synchronous reset
  logic ce = 1'b1; // clock enable, dropped once to stall a read
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, sysResetReq, pwrBtnReq, hostDone;
  logic [1:0] hostKind;
  logic [31:0] hostLen;
  logic [33:0] expRd[$]; // pending read notes {err, data}
  logic [33:0] expPl[$]; // pending pulse notes {kind, length}
  int mismatches = 0;
  int n_checks = 0;

  // 100 ns clock
  always #50 clock = ~clock;

  ecwd_top #(.SEC_CYCLES(SC)) i_dut (.clock(clock), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sysResetReq(sysResetReq), .pwrBtnReq(pwrBtnReq));
  ecwd_host_model i_host (.clock(clock), .rst(rst), .sysResetReq(sysResetReq),
    .pwrBtnReq(pwrBtnReq), .done(hostDone), .kind(hostKind), .len(hostLen));

  // one comparison
  task chk(input string what, input logic [33:0] e, input logic [33:0] s);
    n_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, s);
    end
  endtask

  // one apb transfer; the leading edge keeps transfers apart
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read with its expectation noted first
  task rd(input logic [7:0] a, input logic [31:0] e, input logic err);
    expRd.push_back({1'b0, err, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // wait a bounded time for the noted pulse to be reported
  task waitPulse(input int lim);
    int i;
    for (i = 0; i < lim && expPl.size() != 0; i++) @(posedge clock);
    chk("pulse seen", 34'h0, 34'(expPl.size()));
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // monitor: completed reads and finished requests against the oldest note
  always @(posedge clock)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk("read", expRd.size() ? expRd.pop_front() : 34'h0, {1'b0, pslverr, prdata});
    if (hostDone === 1'b1)
      chk("pulse", expPl.size() ? expPl.pop_front() : 34'h0, {hostKind, hostLen});
  end

  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    tally_and_finish;
  end

  initial
  begin
    int a;
    logic [9:0] t;
    void'($urandom(38009));
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    // reset values, unmapped place, writes while disabled
    rd(ecwd_pkg::OFF_CTRL, 32'h0000_0000, 1'b0);
    rd(ecwd_pkg::OFF_TIMEOUT, 32'h0000_003C, 1'b0);
    rd(ecwd_pkg::OFF_STATUS, 32'h0000_0000, 1'b0);
    rd(8'h14, 32'h0000_0000, 1'b1);
    apb(1'b1, ecwd_pkg::OFF_DELAY, 32'h0000_0005);
    rd(ecwd_pkg::OFF_DELAY, 32'h0000_0000, 1'b0);
    // every action, fired 20 s after a refresh
    for (a = 0; a < 3; a++)
    begin
      apb(1'b1, ecwd_pkg::OFF_CTRL, 32'(1 + 2 * a));
      apb(1'b1, ecwd_pkg::OFF_TIMEOUT, 32'h0000_0014);
      expPl.push_back({(a == 0) ? 2'b10 : 2'b01, (a == 2) ? 32'(4 * SC) : 32'(SC)});
      apb(1'b1, ecwd_pkg::OFF_REFRESH, $urandom);
      repeat (19 * SC) @(posedge clock);
      chk("no early pulse", 34'h1, 34'(expPl.size()));
      waitPulse(8 * SC);
      rd(ecwd_pkg::OFF_CTRL, 32'(2 * a), 1'b0);
    end
    // healthy host keeps it quiet, then disabling stops it
    apb(1'b1, ecwd_pkg::OFF_CTRL, 32'h0000_0003);
    repeat (4)
    begin
      repeat (15 * SC) @(posedge clock);
      apb(1'b1, ecwd_pkg::OFF_REFRESH, $urandom);
    end
    apb(1'b1, ecwd_pkg::OFF_CTRL, 32'h0000_0000);
    rd(ecwd_pkg::OFF_STATUS, 32'h0000_0000, 1'b0);
    repeat (25 * SC) @(posedge clock);
    // limits while enabled, then a 3 s start delay
    apb(1'b1, ecwd_pkg::OFF_CTRL, 32'h0000_0001);
    // action code 3 is refused, the running setting stays
    apb(1'b1, ecwd_pkg::OFF_CTRL, 32'h0000_0007);
    rd(ecwd_pkg::OFF_CTRL, 32'h0000_0001, 1'b0);
    apb(1'b1, ecwd_pkg::OFF_DELAY, 32'h0000_02BC);
    rd(ecwd_pkg::OFF_DELAY, 32'h0000_0258, 1'b0);
    apb(1'b1, ecwd_pkg::OFF_TIMEOUT, 32'h0000_0005);
    rd(ecwd_pkg::OFF_TIMEOUT, 32'h0000_0014, 1'b0);
    t = 10'(20 + $urandom % 581);
    apb(1'b1, ecwd_pkg::OFF_TIMEOUT, 32'(t));
    rd(ecwd_pkg::OFF_TIMEOUT, 32'(t), 1'b0);
    apb(1'b1, ecwd_pkg::OFF_TIMEOUT, 32'h0000_0014);
    apb(1'b1, ecwd_pkg::OFF_DELAY, 32'h0000_0003);
    apb(1'b1, ecwd_pkg::OFF_CTRL, 32'h0000_0000);
    apb(1'b1, ecwd_pkg::OFF_CTRL, 32'h0000_0001);
    expPl.push_back({2'b10, 32'(SC)});
    // two frozen cycles stall the status read and hold the delay count
    ce <= 1'b0;
    fork
      rd(ecwd_pkg::OFF_STATUS, 32'h0003_0001, 1'b0);
      begin
        repeat (2) @(posedge clock);
        ce <= 1'b1;
      end
    join
    repeat (22 * SC) @(posedge clock);
    chk("no early pulse", 34'h1, 34'(expPl.size()));
    waitPulse(8 * SC);
    tally_and_finish;
  end
endmodule
